// File: shared/irg_pkg.sv
// constants, field layouts and types shared by the infrared code generator files
// assumes a single 125 MHz system clock; carrier clock cycles are derived ticks of it
// Operation
// - carrier runs on its own gated clock, at most 16 MHz, apart from bus timing
// - carrier on/off counts reach any frequency between 30 and 60 kHz
// - code FIFO holds 32 words of 16 bits written by software
// - word bit 15 set means digital message, clear means paint message
// - digital word: bits 14:11 hold bit count minus one, bits 10:0 payload
// - paint word: bit 14 picks mark or space, bits 13:0 its length
// - each payload bit becomes a programmed mark and space in programmed order
// - decoder pops words, decodes them and drives the modulator
// - a second repeat FIFO holds software-loaded repeat commands
// - while key held, repeat timer restarts and retransmits without software
// - modulator gate passes carrier during marks and blocks it during spaces
// - output stage may invert the final waveform under a setting
// - time mode drives marks as a steady level without carrier
// - pulse width and pulse distance codes come from programmable bit timings
// - Manchester codes come from bit-value dependent mark/space order
// - interrupt is raised when a transmission has completed
// - carrier shape set by on and off times in carrier clock cycles
// - separate order settings for one and zero choose mark first or space first
// - retransmit interval comes from a programmable repeat time
package irg_pkg;
	localparam int ADDR_W      = 8;
	localparam int WORD_W      = 16;
	localparam int CODE_DEPTH  = 32;
	localparam int REP_DEPTH   = 32;
	localparam int CLK_MHZ     = 125;
	localparam int CAR_MAX_MHZ = 16;
	localparam logic [7:0] CLKDIV_MIN = 8'((CLK_MHZ + CAR_MAX_MHZ - 1) / CAR_MAX_MHZ);

	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CAR_ON    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_CAR_OFF   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_ONE_MARK  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ONE_SPACE = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_ZERO_MARK = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_ZERO_SPC  = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_REP_TIME  = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_CODE_PUSH = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_REP_PUSH  = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_CLK_DIV   = 8'h2c;

	// generator_control bits
	localparam int CTRL_TRIGGER   = 0;
	localparam int CTRL_ONE_ORDER = 1;
	localparam int CTRL_ZERO_ORDR = 2;
	localparam int CTRL_INVERT    = 3;
	localparam int CTRL_TIME_MODE = 4;
	localparam int CTRL_KEY_HELD  = 5;
	localparam int CTRL_CLK_GATE  = 6;
	localparam int CTRL_REP_FLUSH = 7;
	localparam logic [7:0] CTRL_KEEP = 8'h7e;
	localparam logic [7:0] CTRL_RST  = 8'h00;

	// status bits
	localparam int ST_DONE       = 0;
	localparam int ST_BUSY       = 1;
	localparam int ST_CODE_EMPTY = 2;
	localparam int ST_CODE_FULL  = 3;
	localparam int ST_REP_EMPTY  = 4;
	localparam int ST_REP_FULL   = 5;
	localparam int ST_LVL_LSB    = 8;

	// code word layout
	localparam int W_TYPE     = 15;
	localparam int W_LEN_LSB  = 11;
	localparam int W_SYM      = 14;
	localparam logic [3:0] LEN_MAX = 4'ha;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic       CAR_START_LEVEL = 1'b1;

	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_DECODE, S_BIT, S_PAINT, S_REPWAIT} irg_state_e;
endpackage

// File: hw/irg_fifo.sv
// word FIFO with registered read data; optional replay keeps popped words for rewind
// assumes DEPTH is a power of two and that pop and rewind never come in the same cycle
`timescale 1ns/100ps
module irg_fifo import irg_pkg::*; #(
	parameter int W      = irg_pkg::WORD_W,
	parameter int DEPTH  = irg_pkg::CODE_DEPTH,
	parameter bit REPLAY = 1'b0
) (
	// clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	// fill side
	input  wire logic                       push,
	input  wire logic [W-1:0]               wdata,
	input  wire logic                       flush,
	// drain side
	input  wire logic                       pop,
	input  wire logic                       rewind,
	output logic      [W-1:0]               rdata,
	output logic                            empty,
	output logic                            full,
	output logic      [$clog2(DEPTH):0]     level
);
	import irg_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] ONE_P = AW'(1);
	localparam logic [AW:0]   ONE_C = (AW+1)'(1);
	localparam logic [AW:0]   FULL_C = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             cnt;
		logic [AW:0]             played;
		logic [W-1:0]            rdata;
	} irg_fifo_s;

	irg_fifo_s st;
	irg_fifo_s next_st;

	// replayed words still occupy their slots, so they count against full
	assign empty = (st.cnt == '0);
	assign full  = ((st.cnt + st.played) == FULL_C);
	assign level = st.cnt;
	assign rdata = st.rdata;

	always_comb begin
		next_st = st;
		next_st.rdata = st.mem[st.rd];
		if (flush) begin
			next_st.rd = st.wr;
			next_st.cnt = '0;
			next_st.played = '0;
		end else begin
			if (REPLAY && rewind) begin
				next_st.rd = st.rd - st.played[AW-1:0];
				next_st.cnt = st.cnt + st.played;
				next_st.played = '0;
			end else if (pop && !empty) begin
				next_st.rd = st.rd + ONE_P;
				next_st.cnt = st.cnt - ONE_C;
				if (REPLAY) begin
					next_st.played = st.played + ONE_C;
				end
			end
			if (push && !full) begin
				next_st.mem[st.wr] = wdata;
				next_st.wr = st.wr + ONE_P;
				next_st.cnt = next_st.cnt + ONE_C;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// File: hw/irg_carrier.sv
// carrier pulse train counted in carrier clock ticks; restarts at the on phase each mark
// assumes tick is a one-cycle pulse per carrier clock cycle
`timescale 1ns/100ps
module irg_carrier import irg_pkg::*; (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// timing
	input  wire logic        tick,
	input  wire logic        run,
	input  wire logic [15:0] on_time,
	input  wire logic [15:0] off_time,
	// pulse train
	output logic             carrier
);
	import irg_pkg::*;
	localparam logic [15:0] ONE = 16'h0001;

	typedef struct packed {
		logic [15:0] cnt;
		logic        level;
	} irg_car_s;

	irg_car_s st;
	irg_car_s next_st;

	assign carrier = st.level;

	always_comb begin
		next_st = st;
		if (!run) begin
			next_st.cnt = '0;
			next_st.level = CAR_START_LEVEL;
		end else if (tick) begin
			if ((st.cnt + ONE) >= (st.level ? on_time : off_time)) begin
				next_st.cnt = '0;
				next_st.level = ~st.level;
			end else begin
				next_st.cnt = st.cnt + ONE;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st.cnt <= '0;
			st.level <= CAR_START_LEVEL;
		end else begin
			st <= next_st;
		end
	end
endmodule

// File: hw/irg_top.sv
// infrared code generator: register slave, code and repeat queues, decoder, modulator
// assumes an AXI4-Lite master on the 125 MHz clock and an emitter driver on IR_OUT
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module irg_top import irg_pkg::*; #(
	parameter int DEPTH     = irg_pkg::CODE_DEPTH,
	parameter int REP_DEPTH = irg_pkg::REP_DEPTH
) (
	// clock and reset
	input  wire logic                        MCLK,
	input  wire logic                        RST_N,
	// write address
	input  wire logic [irg_pkg::ADDR_W-1:0]  AWADDR,
	input  wire logic                        AWVALID,
	output logic                             AWREADY,
	// write data
	input  wire logic [31:0]                 WDATA,
	input  wire logic [3:0]                  WSTRB,
	input  wire logic                        WVALID,
	output logic                             WREADY,
	// write response
	output logic      [1:0]                  BRESP,
	output logic                             BVALID,
	input  wire logic                        BREADY,
	// read address
	input  wire logic [irg_pkg::ADDR_W-1:0]  ARADDR,
	input  wire logic                        ARVALID,
	output logic                             ARREADY,
	// read data
	output logic      [31:0]                 RDATA,
	output logic      [1:0]                  RRESP,
	output logic                             RVALID,
	input  wire logic                        RREADY,
	// emitter and processor
	output logic                             IR_OUT,
	output logic                             IRQ
);
	import irg_pkg::*;
	localparam int LVL_W = $clog2(DEPTH) + 1;
	localparam int RLVL_W = $clog2(REP_DEPTH) + 1;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [31:0] REP_ONE = 32'h00000001;
	localparam logic [7:0]  DIV_ONE = 8'h01;
	localparam logic [3:0]  BIT_ONE = 4'h1;

	typedef struct packed {
		logic              aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_full;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic [7:0]        ctrl;
		logic [15:0]       car_on;
		logic [15:0]       car_off;
		logic [15:0]       one_mark;
		logic [15:0]       one_space;
		logic [15:0]       zero_mark;
		logic [15:0]       zero_space;
		logic [31:0]       rep_time;
		logic [7:0]        clk_div;
		logic [7:0]        div_cnt;
		logic              tick;
		irg_state_e        state;
		logic              src;
		logic              done;
		logic              mark;
		logic              phase;
		logic              out;
		logic [15:0]       word;
		logic [15:0]       cnt;
		logic [3:0]        bit_idx;
		logic [31:0]       rep_cnt;
	} irg_top_s;

	irg_top_s st;
	irg_top_s next_st;

	// byte-lane merge for register writes
	function automatic logic [31:0] irg_merge(input logic [31:0] old, input logic [31:0] wv,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = wv[8*i +: 8];
			end
		end
		return r;
	endfunction

	// level and length of one half of a payload bit
	function automatic logic [16:0] irg_symbol(input irg_top_s s, input logic b, input logic ph);
		logic mark_first;
		logic mk;
		mark_first = ~(b ? s.ctrl[CTRL_ONE_ORDER] : s.ctrl[CTRL_ZERO_ORDR]);
		mk = ph ? ~mark_first : mark_first;
		if (b) begin
			return {mk, mk ? s.one_mark : s.one_space};
		end
		return {mk, mk ? s.zero_mark : s.zero_space};
	endfunction

	logic              code_push;
	logic              code_pop;
	logic [WORD_W-1:0] code_data;
	logic              code_empty;
	logic              code_full;
	logic [LVL_W-1:0]  code_level;
	logic              rep_push;
	logic              rep_pop;
	logic              rep_rewind;
	logic              rep_flush;
	logic [WORD_W-1:0] rep_data;
	logic              rep_empty;
	logic              rep_full;
	logic              carrier;
	logic [31:0]       wmerged;
	logic [31:0]       status_v;
	logic [16:0]       sym;
	logic [15:0]       word;
	logic [3:0]        len;
	logic              fin;
	logic              src_empty;
	logic [7:0]        div_w;

	irg_fifo #(
		.W      (WORD_W),
		.DEPTH  (DEPTH),
		.REPLAY (1'b0)
	) u_code (
		.mclk   (MCLK),
		.rst_n  (RST_N),
		.push   (code_push),
		.wdata  (st.w_data[WORD_W-1:0]),
		.flush  (1'b0),
		.pop    (code_pop),
		.rewind (1'b0),
		.rdata  (code_data),
		.empty  (code_empty),
		.full   (code_full),
		.level  (code_level)
	);

	irg_fifo #(
		.W      (WORD_W),
		.DEPTH  (REP_DEPTH),
		.REPLAY (1'b1)
	) u_repeat (
		.mclk   (MCLK),
		.rst_n  (RST_N),
		.push   (rep_push),
		.wdata  (st.w_data[WORD_W-1:0]),
		.flush  (rep_flush),
		.pop    (rep_pop),
		.rewind (rep_rewind),
		.rdata  (rep_data),
		.empty  (rep_empty),
		.full   (rep_full),
		.level  ()
	);

	irg_carrier u_carrier (
		.mclk     (MCLK),
		.rst_n    (RST_N),
		.tick     (st.tick),
		.run      (st.mark),
		.on_time  (st.car_on),
		.off_time (st.car_off),
		.carrier  (carrier)
	);

	assign AWREADY = ~st.aw_full;
	assign WREADY  = ~st.w_full;
	assign ARREADY = ~st.rvalid;
	assign BVALID  = st.bvalid;
	assign BRESP   = st.bresp;
	assign RVALID  = st.rvalid;
	assign RDATA   = st.rdata;
	assign RRESP   = st.rresp;
	assign IR_OUT  = st.out;
	assign IRQ     = st.done;

	always_comb begin
		next_st = st;
		code_push = 1'b0;
		code_pop = 1'b0;
		rep_push = 1'b0;
		rep_pop = 1'b0;
		rep_rewind = 1'b0;
		rep_flush = 1'b0;
		sym = '0;
		word = st.src ? rep_data : code_data;
		len = (word[W_TYPE-1:W_LEN_LSB] > LEN_MAX) ? LEN_MAX : word[W_TYPE-1:W_LEN_LSB];
		fin = st.tick && (st.cnt <= CNT_ONE);
		src_empty = st.src ? rep_empty : code_empty;
		wmerged = '0;
		div_w = '0;

		status_v = '0;
		status_v[ST_DONE] = st.done;
		status_v[ST_BUSY] = (st.state != S_IDLE);
		status_v[ST_CODE_EMPTY] = code_empty;
		status_v[ST_CODE_FULL] = code_full;
		status_v[ST_REP_EMPTY] = rep_empty;
		status_v[ST_REP_FULL] = rep_full;
		status_v[ST_LVL_LSB +: LVL_W] = code_level;

		// read channel: one outstanding read, answered the cycle after acceptance
		if (st.rvalid && RREADY) begin
			next_st.rvalid = 1'b0;
		end
		if (ARVALID && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = '0;
			case (ARADDR)
				OFF_CTRL:      next_st.rdata[7:0] = st.ctrl;
				OFF_STATUS:    next_st.rdata = status_v;
				OFF_CAR_ON:    next_st.rdata[15:0] = st.car_on;
				OFF_CAR_OFF:   next_st.rdata[15:0] = st.car_off;
				OFF_ONE_MARK:  next_st.rdata[15:0] = st.one_mark;
				OFF_ONE_SPACE: next_st.rdata[15:0] = st.one_space;
				OFF_ZERO_MARK: next_st.rdata[15:0] = st.zero_mark;
				OFF_ZERO_SPC:  next_st.rdata[15:0] = st.zero_space;
				OFF_REP_TIME:  next_st.rdata = st.rep_time;
				OFF_CLK_DIV:   next_st.rdata[7:0] = st.clk_div;
				OFF_CODE_PUSH, OFF_REP_PUSH: next_st.rdata = '0;
				default:       next_st.rresp = RESP_SLVERR;
			endcase
		end

		// write channel: address and data taken in either order, then committed together
		if (st.bvalid && BREADY) begin
			next_st.bvalid = 1'b0;
		end
		if (AWVALID && !st.aw_full) begin
			next_st.aw_full = 1'b1;
			next_st.aw_addr = AWADDR;
		end
		if (WVALID && !st.w_full) begin
			next_st.w_full = 1'b1;
			next_st.w_data = WDATA;
			next_st.w_strb = WSTRB;
		end
		if (st.aw_full && st.w_full && !st.bvalid) begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			case (st.aw_addr)
				OFF_CTRL: begin
					wmerged = irg_merge({24'h000000, st.ctrl}, st.w_data, st.w_strb);
					next_st.ctrl = wmerged[7:0] & CTRL_KEEP;
					rep_flush = wmerged[CTRL_REP_FLUSH] & st.w_strb[0];
				end
				OFF_STATUS: begin
					if (st.w_strb[0] && st.w_data[ST_DONE]) begin
						next_st.done = 1'b0;
					end
				end
				OFF_CAR_ON:    next_st.car_on = 16'(irg_merge({16'h0000, st.car_on}, st.w_data, st.w_strb));
				OFF_CAR_OFF:   next_st.car_off = 16'(irg_merge({16'h0000, st.car_off}, st.w_data, st.w_strb));
				OFF_ONE_MARK:  next_st.one_mark = 16'(irg_merge({16'h0000, st.one_mark}, st.w_data, st.w_strb));
				OFF_ONE_SPACE: next_st.one_space = 16'(irg_merge({16'h0000, st.one_space}, st.w_data, st.w_strb));
				OFF_ZERO_MARK: next_st.zero_mark = 16'(irg_merge({16'h0000, st.zero_mark}, st.w_data, st.w_strb));
				OFF_ZERO_SPC:  next_st.zero_space = 16'(irg_merge({16'h0000, st.zero_space}, st.w_data, st.w_strb));
				OFF_REP_TIME:  next_st.rep_time = irg_merge(st.rep_time, st.w_data, st.w_strb);
				OFF_CLK_DIV: begin
					// a divider below the minimum would push the carrier clock over its ceiling
					div_w = 8'(irg_merge({24'h000000, st.clk_div}, st.w_data, st.w_strb));
					next_st.clk_div = (div_w < CLKDIV_MIN) ? CLKDIV_MIN : div_w;
				end
				OFF_CODE_PUSH: begin
					code_push = ~code_full;
					next_st.bresp = code_full ? RESP_SLVERR : RESP_OKAY;
				end
				OFF_REP_PUSH: begin
					rep_push = ~rep_full;
					next_st.bresp = rep_full ? RESP_SLVERR : RESP_OKAY;
				end
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end

		// carrier clock: gated divided tick of the system clock
		next_st.tick = 1'b0;
		if (st.ctrl[CTRL_CLK_GATE]) begin
			if (st.div_cnt >= (st.clk_div - DIV_ONE)) begin
				next_st.div_cnt = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.div_cnt = st.div_cnt + DIV_ONE;
			end
		end else begin
			next_st.div_cnt = '0;
		end

		// decoder and modulator sequencing
		unique case (st.state)
			S_IDLE: begin
				next_st.mark = 1'b0;
				if (st.aw_full && st.w_full && !st.bvalid && st.aw_addr == OFF_CTRL
						&& st.w_strb[0] && st.w_data[CTRL_TRIGGER]) begin
					next_st.src = 1'b0;
					next_st.state = S_FETCH;
				end
			end
			S_FETCH: begin
				if (src_empty) begin
					next_st.mark = 1'b0;
					next_st.done = 1'b1;
					if (st.ctrl[CTRL_KEY_HELD] && !(rep_empty && !st.src)) begin
						next_st.rep_cnt = st.rep_time;
						next_st.state = S_REPWAIT;
					end else begin
						next_st.state = S_IDLE;
					end
				end else begin
					code_pop = ~st.src;
					rep_pop = st.src;
					next_st.state = S_DECODE;
				end
			end
			S_DECODE: begin
				next_st.word = word;
				if (word[W_TYPE]) begin
					next_st.bit_idx = len;
					next_st.phase = 1'b0;
					sym = irg_symbol(st, word[len], 1'b0);
					next_st.mark = sym[16];
					next_st.cnt = sym[15:0];
					next_st.state = S_BIT;
				end else begin
					next_st.mark = word[W_SYM];
					next_st.cnt = {2'b00, word[W_SYM-1:0]};
					next_st.state = S_PAINT;
				end
			end
			S_BIT: begin
				if (fin) begin
					if (!st.phase) begin
						sym = irg_symbol(st, st.word[st.bit_idx], 1'b1);
						next_st.phase = 1'b1;
						next_st.mark = sym[16];
						next_st.cnt = sym[15:0];
					end else if (st.bit_idx == '0) begin
						next_st.state = S_FETCH;
					end else begin
						sym = irg_symbol(st, st.word[st.bit_idx - BIT_ONE], 1'b0);
						next_st.bit_idx = st.bit_idx - BIT_ONE;
						next_st.phase = 1'b0;
						next_st.mark = sym[16];
						next_st.cnt = sym[15:0];
					end
				end else if (st.tick) begin
					next_st.cnt = st.cnt - CNT_ONE;
				end
			end
			S_PAINT: begin
				if (fin) begin
					next_st.state = S_FETCH;
				end else if (st.tick) begin
					next_st.cnt = st.cnt - CNT_ONE;
				end
			end
			S_REPWAIT: begin
				if (!st.ctrl[CTRL_KEY_HELD]) begin
					next_st.state = S_IDLE;
				end else if (st.tick) begin
					if (st.rep_cnt <= REP_ONE) begin
						rep_rewind = 1'b1;
						next_st.src = 1'b1;
						next_st.state = S_FETCH;
					end else begin
						next_st.rep_cnt = st.rep_cnt - REP_ONE;
					end
				end
			end
		endcase

		// modulator gate and output stage
		next_st.out = st.ctrl[CTRL_INVERT] ^ (st.mark & (st.ctrl[CTRL_TIME_MODE] | carrier));
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st <= '0;
			st.ctrl <= CTRL_RST;
			st.clk_div <= CLKDIV_MIN;
			st.state <= S_IDLE;
		end else begin
			st <= next_st;
		end
	end
endmodule

// File: sim/irg_sva.sv
// checker on irg_top ports: bus handshakes and done flag
// assumes one clock and an async active-low reset
`timescale 1ns/100ps
module irg_sva import irg_pkg::*; #(
	parameter int DEPTH     = 32,
	parameter int REP_DEPTH = 32
) (
	// watched ports
	input wire logic       MCLK,
	input wire logic       RST_N,
	input wire logic       AWVALID,
	input wire logic       AWREADY,
	input wire logic       WVALID,
	input wire logic       WREADY,
	input wire logic [1:0] BRESP,
	input wire logic       BVALID,
	input wire logic       BREADY,
	input wire logic       ARVALID,
	input wire logic       ARREADY,
	input wire logic       RVALID,
	input wire logic       RREADY,
	input wire logic       IRQ
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
		else $error("write response late");
	a_b_release: assert property (BVALID && BREADY |=> !BVALID) else $error("bvalid stuck");
	a_ready_back: assert property ($rose(BVALID) |-> AWREADY && WREADY) else $error("ready not back");
	a_resp_legal: assert property (BVALID |-> BRESP == RESP_OKAY || BRESP == RESP_SLVERR)
		else $error("bad bresp");
	a_read_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("read answer late");
	a_r_release: assert property (RVALID && RREADY |=> !RVALID) else $error("rvalid stuck");
	a_ar_block: assert property (RVALID |-> !ARREADY) else $error("ar taken during rvalid");
	a_irq_clear: assert property ($fell(IRQ) |-> $rose(BVALID)) else $error("irq fell alone");
	c_done: cover property ($rose(IRQ));
	c_slverr: cover property (BVALID && BRESP == RESP_SLVERR);
	c_read: cover property (RVALID && RREADY);
endmodule
bind irg_top irg_sva #(.DEPTH(DEPTH), .REP_DEPTH(REP_DEPTH)) irg_sva_i (.MCLK(MCLK), .RST_N(RST_N),
	.AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
	.BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
	.RREADY(RREADY), .IRQ(IRQ));

// File: sim/irg_emitter.sv
// emitter model: counts rising edges of the drive pin
// assumes the pin changes only on mclk edges
`timescale 1ns/100ps
module irg_emitter (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// drive pin
	input wire logic ir_out,
	output int       rises
);
	logic last;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			last  <= 1'b0;
			rises <= 0;
		end else begin
			last <= ir_out;
			if (ir_out && !last)
				rises <= rises + 1;
		end
	end
endmodule

// File: sim/irg_top_tb_top.sv
// bench for irg_top: bus tasks, pulse counts from the emitter model
// assumes irg_sva is bound and irg_emitter counts rising edges
`timescale 1ns/100ps
module irg_top_tb_top;
	import irg_pkg::*;
	logic        MCLK = 0, RST_N = 0;
	logic [7:0]  AWADDR = 0, ARADDR = 0, ctl;
	logic [31:0] WDATA = 0, RDATA;
	logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IR_OUT, IRQ;
	logic [1:0]  BRESP, RRESP, bq[$];
	logic [33:0] rq[$];
	logic [3:0]  ln;
	int          num_errors = 0, n_tests = 0, cyc = 0, rises, r0, i, k, d;

	irg_top irg_top_i (.MCLK(MCLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
		.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IR_OUT(IR_OUT), .IRQ(IRQ));
	irg_emitter irg_emitter_i (.mclk(MCLK), .rst_n(RST_N), .ir_out(IR_OUT), .rises(rises));

	initial forever #4 MCLK = ~MCLK;

	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard: whole run needs far fewer cycles
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 50000) begin
			num_errors++;
			test_done;
		end
	end

	// answers are compared in issue order
	always @(posedge MCLK) begin
		if (RVALID && RREADY)
			chk("read", {RRESP, RDATA}, rq.pop_front());
		if (BVALID && BREADY)
			chk("bresp", {32'h0, BRESP}, {32'h0, bq.pop_front()});
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = RESP_OKAY);
		bq.push_back(r);
		@(posedge MCLK);
		AWADDR  <= a;
		WDATA   <= v;
		AWVALID <= 1;
		WVALID  <= 1;
		BREADY  <= 1;
		do begin
			@(posedge MCLK);
			if (AWREADY)
				AWVALID <= 0;
			if (WREADY)
				WVALID <= 0;
		end while (!BVALID);
		BREADY <= 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = RESP_OKAY);
		rq.push_back({r, v});
		@(posedge MCLK);
		ARADDR  <= a;
		ARVALID <= 1;
		RREADY  <= 1;
		do begin
			@(posedge MCLK);
			if (ARREADY)
				ARVALID <= 0;
		end while (!RVALID);
		RREADY <= 0;
	endtask

	// optional trigger, wait for done, clear it, then count rising edges seen (marks in time mode, carrier pulses otherwise)
	task automatic tx(input int e, input bit t = 1);
		r0 = rises;
		if (t)
			wr(OFF_CTRL, {24'h0, ctl | 8'h01});
		for (i = 0; i < 4000 && IRQ !== 1'b1; i++)
			@(posedge MCLK);
		chk("irq", {33'h0, IRQ}, 34'h1);
		wr(OFF_STATUS, 32'h1);
		chk("irq clr", {33'h0, IRQ}, 34'h0);
		chk("marks", 34'(rises - r0), 34'(e));
	endtask

	initial begin
		void'($urandom(31));
		ctl = 8'h50;
		repeat (20) @(posedge MCLK);
		RST_N <= 1;
		chk("idle", {33'h0, IR_OUT}, 34'h0);
		rd(OFF_CTRL, 0);
		rd(OFF_STATUS, 32'h14);
		rd(OFF_CLK_DIV, 8);
		rd(8'h30, 0, RESP_SLVERR);
		wr(8'h30, 1, RESP_SLVERR);
		wr(OFF_CLK_DIV, 3);
		rd(OFF_CLK_DIV, 8);
		d = 8 + $urandom % 8;
		wr(OFF_CLK_DIV, d);
		rd(OFF_CLK_DIV, d);
		$display("regs done");
		wr(OFF_ONE_MARK, 2);
		wr(OFF_ONE_SPACE, 4);
		wr(OFF_ZERO_MARK, 2);
		wr(OFF_ZERO_SPC, 2);
		wr(OFF_CTRL, ctl);
		for (k = 0; k < 32; k++)
			wr(OFF_CODE_PUSH, 1);
		wr(OFF_CODE_PUSH, 1, RESP_SLVERR);
		rd(OFF_STATUS, 32'h2018);
		tx(0);
		$display("fifo done");
		for (k = 0; k < 3; k++) begin
			ln = k == 0 ? 4'h0 : k == 1 ? LEN_MAX : 4'hf;
			wr(OFF_CODE_PUSH, {16'h0, 1'b1, ln, 11'h0});
			tx(ln > LEN_MAX ? 11 : ln + 1);
		end
		ctl = 8'h52;
		wr(OFF_CODE_PUSH, 16'h8802);
		tx(1);
		wr(OFF_CODE_PUSH, 16'h8801);
		tx(2);
		// zero bit space first: the two marks meet and merge into one
		ctl = 8'h54;
		wr(OFF_CODE_PUSH, 16'h8801);
		tx(1);
		ctl = 8'h58;
		wr(OFF_CTRL, ctl);
		repeat (3) @(posedge MCLK);
		chk("inv idle", {33'h0, IR_OUT}, 34'h1);
		wr(OFF_CODE_PUSH, 16'h8800);
		tx(2);
		$display("digital done");
		ctl = 8'h40;
		d = 2 + $urandom % 3;
		k = 2 + $urandom % 3;
		wr(OFF_CAR_ON, d);
		wr(OFF_CAR_OFF, k);
		wr(OFF_CODE_PUSH, {16'h0, 2'b01, 14'(4 * (d + k) - 2)});
		tx(4);
		ctl = 8'h70;
		wr(OFF_REP_TIME, 20);
		wr(OFF_REP_PUSH, 16'h8000);
		wr(OFF_CODE_PUSH, 16'h8000);
		tx(1);
		tx(1, 0);
		ctl = 8'h50;
		wr(OFF_CTRL, ctl);
		repeat (400) @(posedge MCLK);
		rd(OFF_STATUS, 32'h14);
		wr(OFF_REP_PUSH, 16'h8000);
		rd(OFF_STATUS, 32'h4);
		wr(OFF_CTRL, 8'hd0);
		rd(OFF_STATUS, 32'h14);
		$display("carrier and repeat done");
		test_done;
	end
endmodule
